// ===== src/dramrf_pkg.sv
// Shared constants for the refresh / self-refresh link: timing, registers, states.
// Assumes a 40 MHz system clock on both ends; link clock is made by the controller.
package dramrf_pkg;
    // System clock and derived link clock
    localparam int SYS_NS  = 25;
    localparam int CK_HALF = 4;                     // System cycles per half link clock
    localparam int CK_NS   = 2 * CK_HALF * SYS_NS;  // Link clock period, 200 ns

    // Timing figures in ns, converted to link clocks (least: round up, longest: round down)
    localparam int TRFC_NS    = 110;
    localparam int TREFI_NS   = 7800;
    localparam int TXS_NS     = 120;
    localparam int TWR_NS     = 15;
    localparam int TWTR_NS    = 8;
    localparam int TRFC_NCK   = (TRFC_NS + CK_NS - 1) / CK_NS;
    localparam int TREFI_NCK  = TREFI_NS / CK_NS;
    localparam int TXS_NCK    = (TXS_NS + CK_NS - 1) / CK_NS;
    localparam int TWR_NCK    = (TWR_NS + CK_NS - 1) / CK_NS;
    localparam int TWTR_NCK   = (TWTR_NS + CK_NS - 1) / CK_NS;
    localparam int TXSDLL_NCK = 512;
    localparam int VREF_NCK   = 512;
    localparam int TCKESR_NCK = 4;
    localparam int TRP_NCK    = 2;
    localparam int WL_NCK     = 5;
    localparam int ODTL_NCK   = WL_NCK - 2;
    localparam int DEBT_MAX   = 8;

    // Device-side times in system cycles
    localparam int TRFC_CYC   = (TRFC_NS + SYS_NS - 1) / SYS_NS;
    localparam int SRREF_CYC  = TREFI_NS / SYS_NS;

    // Burst length field values
    localparam logic [1:0] BURST_FIXED8 = 2'h0;
    localparam logic [1:0] BURST_OTF    = 2'h1;
    localparam logic [1:0] BURST_CHOP4  = 2'h2;

    // Register offsets and fields
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_WRCMD  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_AUTO  = 0;
    localparam int CTRL_SRREQ = 1;
    localparam int CTRL_VREF  = 2;
    localparam int CTRL_PULL  = 3;
    localparam int ST_DEBT    = 8;
    localparam int ST_SR      = 16;
    localparam int ST_NEEDREF = 17;
    localparam int ST_WRBUSY  = 18;
    localparam int ST_WRPEND  = 19;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Controller states
    typedef enum logic [7:0] {
        DRAMRF_C_IDLE  = 8'h01,
        DRAMRF_C_REF   = 8'h02,
        DRAMRF_C_WR    = 8'h04,
        DRAMRF_C_ODT   = 8'h08,
        DRAMRF_C_SR    = 8'h10,
        DRAMRF_C_XS    = 8'h20,
        DRAMRF_C_XSDLL = 8'h40
    } dramrf_cst_t;

    // Device states
    typedef enum logic [2:0] {
        DRAMRF_D_IDLE = 3'h1,
        DRAMRF_D_REF  = 3'h2,
        DRAMRF_D_SELF = 3'h4
    } dramrf_dst_t;
endpackage : dramrf_pkg

// ===== src/dramrf_link_if.sv
// Command pins between controller and memory device.
// Assumes both ends see the same wires; no bidirectional pins in this block.
`timescale 1ns/1ps
interface dramrf_link_if;
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic a12;
    logic reset_n;

    modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, odt, a12, reset_n);
    modport dram (input ck, cke, cs_n, ras_n, cas_n, we_n, odt, a12, reset_n);
endinterface : dramrf_link_if

// ===== src/dramrf_dram.sv
// Memory device end: refresh, self-refresh, burst length decode.
// Assumes link pins arrive asynchronously; all but ODT are synchronised on clk_sys_i.
`timescale 1ns/1ps
module dramrf_dram
    import dramrf_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    dramrf_link_if.dram      link,
    input  wire logic [1:0]  mode_bl_i,
    input  wire logic        dll_en_i,
    output logic             self_ref_o,
    output logic             refreshing_o,
    output logic             banks_idle_o,
    output logic [13:0]      row_ctr_o,
    output logic             dll_on_o,
    output logic             dll_reset_o,
    output logic             wr_seen_o,
    output logic             wr_bl8_o
);
    logic [7:0]  s1_reg;
    logic [7:0]  s2_reg;
    logic        ck_prev_reg;
    logic        cke_prev_reg;
    logic [8:0]  tmr_reg;
    dramrf_dst_t st_reg;
    logic        rise;
    logic        cke_s;
    logic        rstpin_n;
    logic        cmd_ref;
    logic        cmd_wr;
    logic        start_ref;

    // Two-stage synchroniser on all pins but ODT
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
        end else begin
            s1_reg <= {link.reset_n, link.a12, link.we_n, link.cas_n,
                       link.ras_n, link.cs_n, link.cke, link.ck};
            s2_reg <= s1_reg;
        end
    end

    // Decode on link clock rising edge
    assign rise     = s2_reg[0] & ~ck_prev_reg;
    assign cke_s    = s2_reg[1];
    assign rstpin_n = s2_reg[7];
    assign cmd_ref  = ~s2_reg[2] & ~s2_reg[3] & ~s2_reg[4] & s2_reg[5];
    assign cmd_wr   = ~s2_reg[2] & s2_reg[3] & ~s2_reg[4] & ~s2_reg[5] & cke_s;
    assign start_ref = (st_reg == DRAMRF_D_SELF) && (tmr_reg == 9'h000);

    // Edge history
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ck_prev_reg  <= 1'b0;
            cke_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg <= s2_reg[0];
            if (rise) begin
                cke_prev_reg <= cke_s;
            end
        end
    end

    // Main state machine; only CKE and RESET# matter in self-refresh
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg       <= DRAMRF_D_IDLE;
            tmr_reg      <= 9'h000;
            refreshing_o <= 1'b0;
            banks_idle_o <= 1'b1;
            self_ref_o   <= 1'b0;
        end else if (!rstpin_n) begin
            st_reg       <= DRAMRF_D_IDLE;
            tmr_reg      <= 9'h000;
            refreshing_o <= 1'b0;
            banks_idle_o <= 1'b1;
            self_ref_o   <= 1'b0;
        end else begin
            case (st_reg)
                DRAMRF_D_IDLE: begin
                    if (rise && cmd_ref && cke_prev_reg && cke_s) begin
                        st_reg       <= DRAMRF_D_REF;
                        tmr_reg      <= 9'(TRFC_CYC);
                        refreshing_o <= 1'b1;
                        banks_idle_o <= 1'b0;
                    end else if (rise && cmd_ref && cke_prev_reg && !cke_s) begin
                        st_reg     <= DRAMRF_D_SELF;
                        tmr_reg    <= 9'h000;                    // First refresh at once
                        self_ref_o <= 1'b1;
                    end
                end
                DRAMRF_D_REF: begin
                    if (tmr_reg == 9'h001) begin
                        st_reg       <= DRAMRF_D_IDLE;
                        refreshing_o <= 1'b0;
                        banks_idle_o <= 1'b1;                   // All banks precharged
                    end
                    tmr_reg <= tmr_reg - 9'h001;
                end
                DRAMRF_D_SELF: begin
                    if (cke_s) begin                           // Exit on CKE level, clock may be stopped
                        st_reg       <= DRAMRF_D_IDLE;
                        self_ref_o   <= 1'b0;
                        refreshing_o <= 1'b0;
                        banks_idle_o <= 1'b1;
                    end else if (start_ref) begin              // Own timer keeps data
                        tmr_reg      <= 9'(SRREF_CYC);
                        refreshing_o <= 1'b1;
                    end else begin
                        tmr_reg <= tmr_reg - 9'h001;
                        if (tmr_reg == 9'(SRREF_CYC - TRFC_CYC)) begin
                            refreshing_o <= 1'b0;
                        end
                    end
                end
                default: begin
                    st_reg <= DRAMRF_D_IDLE;
                end
            endcase
        end
    end

    // Internal row counter, address bus ignored
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            row_ctr_o <= 14'h0000;
        end else if ((st_reg == DRAMRF_D_IDLE && rise && cmd_ref && cke_prev_reg && cke_s) || start_ref) begin
            row_ctr_o <= row_ctr_o + 14'h0001;
        end
    end

    // DLL off in self-refresh, back on with reset at exit
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dll_on_o    <= 1'b0;
            dll_reset_o <= 1'b0;
        end else begin
            dll_reset_o <= dll_en_i && st_reg == DRAMRF_D_SELF && cke_s && rstpin_n;
            dll_on_o    <= dll_en_i && st_reg != DRAMRF_D_SELF;
        end
    end

    // Write burst length decode
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_seen_o <= 1'b0;
            wr_bl8_o  <= 1'b0;
        end else begin
            wr_seen_o <= rise && cmd_wr && st_reg == DRAMRF_D_IDLE;
            if (rise && cmd_wr && st_reg == DRAMRF_D_IDLE) begin
                wr_bl8_o <= mode_bl_i == BURST_FIXED8 || (mode_bl_i == BURST_OTF && s2_reg[6]);
            end
        end
    end
endmodule : dramrf_dram

// ===== src/dramrf_ctrl.sv
// Memory controller end: refresh scheduling, self-refresh entry/exit, writes.
// Assumes APB software access on clk_sys_i; makes the link clock by a divider.
//
// Operation
// - Refresh decoded on CS RAS CAS low, WE high
// - All banks idle tRP before refresh
// - Refresh uses internal rows, leaves banks idle
// - Only NOP after refresh until tRFC
// - Postpone at most eight refreshes
// - Pull in at most eight refreshes; more are still issued, only the debt stops at minus eight
// - At most sixteen refreshes per two intervals; not enforced, pull-ins are issued without limit
// - Refresh debt frozen during self-refresh
// - Self-refresh entry decoded with CKE low
// - Entry only when idle, timings met
// - ODT low ODTL plus half before entry
// - Hold CKE low during self-refresh
// - DLL off in self-refresh, reset on exit
// - Self-refresh ignores all but CKE, RESET
// - One internal refresh soon after entry
// - Stay in self-refresh at least tCKESR
// - Writes wait 512 clocks if reference off
// - Exit with CKE high, wait tXS, tXSDLL
// - NOP during tXS, CKE high, ODT off
// - Extra refresh before re-entering self-refresh
// - Burst eight or chop four from field
// - Wait tWR and tWTR after last data
`timescale 1ns/1ps
module dramrf_ctrl
    import dramrf_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [1:0]  mode_bl_i,
    dramrf_link_if.ctrl      link
);
    logic [2:0]  div_reg;
    logic        ck_reg;
    logic        tick;
    logic [3:0]  ctrl_reg;
    logic        wr_pend_reg;
    logic        wr_a12_reg;
    logic        pull_pend_reg;
    logic [5:0]  refi_reg;
    logic signed [4:0] debt_reg;
    logic        need_ref_reg;
    logic [9:0]  cnt_reg;
    logic [9:0]  vref_reg;
    logic [4:0]  rec_reg;
    dramrf_cst_t st_reg;
    logic        do_ref;
    logic        do_wr;
    logic        do_sr;
    logic        ref_due;
    logic        bl8;
    logic        acc;
    logic        hit;
    logic [31:0] status;

    // Link clock divider; commands change at falling edge
    assign tick = (div_reg == 3'h0) && !ck_reg;   // Same edge as the ck pin falls, so commands never move under a high ck
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_reg <= 3'h0;
            ck_reg  <= 1'b0;
        end else if (div_reg == 3'(CK_HALF - 1)) begin
            div_reg <= 3'h0;
            ck_reg  <= ~ck_reg;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // APB slave, one wait state
    assign acc = psel_i & penable_i & pready_o;
    assign hit = paddr_i == REG_CTRL || paddr_i == REG_WRCMD || paddr_i == REG_STATUS;
    always_comb begin
        status = 32'h0000_0000;
        status[7:0] = st_reg;
        status[ST_DEBT +: 5] = debt_reg;
        status[ST_SR] = st_reg == DRAMRF_C_SR;
        status[ST_NEEDREF] = need_ref_reg;
        status[ST_WRBUSY] = rec_reg != 5'h00;
        status[ST_WRPEND] = wr_pend_reg;
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
            if (psel_i & penable_i & ~pready_o) begin
                case (paddr_i)
                    REG_CTRL:   prdata_o <= {28'h000_0000, ctrl_reg};
                    REG_STATUS: prdata_o <= status;
                    default:    prdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register and pending requests; a set wins over the clear
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg      <= CTRL_RST;
            wr_pend_reg   <= 1'b0;
            wr_a12_reg    <= 1'b0;
            pull_pend_reg <= 1'b0;
        end else begin
            if (acc && pwrite_i && paddr_i == REG_CTRL) begin
                ctrl_reg <= {1'b0, pwdata_i[2:0]};
            end
            if (acc && pwrite_i && paddr_i == REG_WRCMD) begin
                wr_pend_reg <= 1'b1;
                wr_a12_reg  <= pwdata_i[0];
            end else if (do_wr) begin
                wr_pend_reg <= 1'b0;
            end
            if (acc && pwrite_i && paddr_i == REG_CTRL && pwdata_i[CTRL_PULL]) begin
                pull_pend_reg <= 1'b1;
            end else if (do_ref) begin
                pull_pend_reg <= 1'b0;
            end
        end
    end

    // Decisions in idle; writes blocked when debt at limit
    assign ref_due = ctrl_reg[CTRL_AUTO] && debt_reg > 5'sd0;
    assign do_ref  = tick && st_reg == DRAMRF_C_IDLE && rec_reg == 5'h00 && cnt_reg == 10'h000
                     && (ref_due || pull_pend_reg || need_ref_reg && ctrl_reg[CTRL_SRREQ]);
    assign do_wr   = tick && st_reg == DRAMRF_C_IDLE && !do_ref && wr_pend_reg
                     && vref_reg == 10'h000 && debt_reg < 5'(DEBT_MAX);
    assign do_sr   = tick && st_reg == DRAMRF_C_IDLE && !do_ref && !do_wr && rec_reg == 5'h00
                     && cnt_reg == 10'h000 && ctrl_reg[CTRL_SRREQ] && !need_ref_reg;
    assign bl8     = mode_bl_i == BURST_FIXED8 || (mode_bl_i == BURST_OTF && wr_a12_reg);

    // Signed refresh debt, frozen in self-refresh
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            refi_reg <= 6'h00;
            debt_reg <= 5'sd0;
        end else if (tick) begin
            if (st_reg == DRAMRF_C_SR) begin
                refi_reg <= refi_reg;
            end else if (refi_reg == 6'(TREFI_NCK - 1)) begin
                refi_reg <= 6'h00;
                if (!do_ref && debt_reg < 5'(DEBT_MAX)) begin
                    debt_reg <= debt_reg + 5'sd1;
                end
            end else begin
                refi_reg <= refi_reg + 6'h01;
                if (do_ref && debt_reg > -5'(DEBT_MAX)) begin
                    debt_reg <= debt_reg - 5'sd1;                  // Pull-in floor
                end
            end
        end
    end

    // Extra refresh needed after a self-refresh exit
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            need_ref_reg <= 1'b0;
        end else if (tick && st_reg == DRAMRF_C_SR && !ctrl_reg[CTRL_SRREQ] && cnt_reg == 10'h000) begin
            need_ref_reg <= 1'b1;
        end else if (do_ref) begin
            need_ref_reg <= 1'b0;
        end
    end

    // Write recovery and write-to-read spacing after last data
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rec_reg <= 5'h00;
        end else if (do_wr) begin
            rec_reg <= 5'(WL_NCK + (bl8 ? 4 : 2) + (TWR_NCK > TWTR_NCK ? TWR_NCK : TWTR_NCK));
        end else if (tick && rec_reg != 5'h00) begin
            rec_reg <= rec_reg - 5'h01;
        end
    end

    // Reference settle window after exit when VREF was off
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vref_reg <= 10'h000;
        end else if (tick && st_reg == DRAMRF_C_SR && !ctrl_reg[CTRL_SRREQ] && cnt_reg == 10'h000) begin
            vref_reg <= ctrl_reg[CTRL_VREF] ? 10'(VREF_NCK) : 10'h000;
        end else if (tick && vref_reg != 10'h000) begin
            vref_reg <= vref_reg - 10'h001;
        end
    end

    // Sequencer and command pins
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg  <= DRAMRF_C_IDLE;
            cnt_reg <= 10'(TRP_NCK);
            link.cke   <= 1'b0;
            link.cs_n  <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n  <= 1'b1;
            link.odt   <= 1'b0;
            link.a12   <= 1'b0;
        end else if (tick) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hf;   // NOP/deselect by default
            link.cke <= 1'b1;
            link.odt <= 1'b0;
            if (cnt_reg != 10'h000) begin
                cnt_reg <= cnt_reg - 10'h001;
            end
            case (st_reg)
                DRAMRF_C_IDLE: begin
                    if (do_ref) begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h1;
                        st_reg  <= DRAMRF_C_REF;
                        cnt_reg <= 10'(TRFC_NCK);
                    end else if (do_wr) begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h4;
                        link.a12 <= wr_a12_reg;
                        st_reg   <= DRAMRF_C_WR;
                    end else if (do_sr) begin
                        st_reg  <= DRAMRF_C_ODT;                   // ODT already low here
                        cnt_reg <= 10'(ODTL_NCK + 1);
                    end
                end
                DRAMRF_C_REF: begin
                    if (cnt_reg <= 10'h001) begin
                        st_reg  <= DRAMRF_C_IDLE;
                        cnt_reg <= 10'h000;
                    end
                end
                DRAMRF_C_WR: begin
                    st_reg <= DRAMRF_C_IDLE;
                end
                DRAMRF_C_ODT: begin
                    if (cnt_reg <= 10'h001) begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h1;
                        link.cke <= 1'b0;                          // Self-refresh entry
                        st_reg   <= DRAMRF_C_SR;
                        cnt_reg  <= 10'(TCKESR_NCK);
                    end
                end
                DRAMRF_C_SR: begin
                    link.cke <= 1'b0;
                    if (!ctrl_reg[CTRL_SRREQ] && cnt_reg == 10'h000) begin
                        link.cke <= 1'b1;                          // Exit with NOP
                        st_reg   <= DRAMRF_C_XS;
                        cnt_reg  <= 10'(TXS_NCK);
                    end
                end
                DRAMRF_C_XS: begin
                    if (cnt_reg <= 10'h001) begin                  // Only NOP during tXS
                        st_reg  <= DRAMRF_C_XSDLL;
                        cnt_reg <= 10'(TXSDLL_NCK - TXS_NCK);
                    end
                end
                DRAMRF_C_XSDLL: begin
                    if (cnt_reg <= 10'h001) begin                  // CKE high, ODT off throughout
                        st_reg  <= DRAMRF_C_IDLE;
                        cnt_reg <= 10'h000;
                    end
                end
                default: begin
                    st_reg <= DRAMRF_C_IDLE;
                end
            endcase
        end
    end

    // Link clock and device reset pins
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link.ck      <= 1'b0;
            link.reset_n <= 1'b0;
        end else begin
            link.ck      <= ck_reg;
            link.reset_n <= 1'b1;
        end
    end
endmodule : dramrf_ctrl

// ===== tb/dramrf_link_checker.sv
// Link checker: command framing, refresh spacing, self-refresh entry and exit.
// Assumes the link signals of one interface and the controller system clock.
`timescale 1ns/1ps
module dramrf_link_checker (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt
);
    logic nop_c;
    logic ref_c;
    logic ref_seen_reg;
    // Command decode
    assign nop_c = cs_n & ras_n & cas_n & we_n;
    assign ref_c = !cs_n & !ras_n & !cas_n & we_n;
    // Refresh seen since the last self-refresh entry
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) ref_seen_reg <= 1'b1;
        else if (ref_c && cke) ref_seen_reg <= 1'b1;
        else if (ref_c) ref_seen_reg <= 1'b0;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Link protocol checks
    odt_stays_off_a: assert property (odt == 1'b0)
        else $error("termination enabled");
    sre_decode_a: assert property ($fell(cke) |-> ref_c)
        else $error("cke fell without entry command");
    cke_hold_a: assert property ($fell(cke) |-> !cke [*8] ##24 !cke)
        else $error("self-refresh left too early");
    ref_then_nop_a: assert property ($fell(ref_c && cke) |-> nop_c)
        else $error("command too soon after refresh");
    exit_nop_a: assert property ($rose(cke) |-> nop_c [*8])
        else $error("command during exit delay");
    cmd_edge_a: assert property ($changed({cs_n, ras_n, cas_n, we_n}) |-> !ck)
        else $error("command changed near rising ck");
    ck_phase_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
        else $error("link clock high phase wrong");
    reentry_ref_a: assert property ($fell(cke) |-> ref_seen_reg)
        else $error("re-entry without extra refresh");
endmodule : dramrf_link_checker

// ===== tb/testbench.sv
// Bench: both link ends joined, controller driven over APB, device outputs watched.
// Assumes 40 MHz system clock shared by both ends.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    import dramrf_pkg::*;
    logic        clk_sys_i, resetn_i, psel, penable, pwrite, pready, pslverr, err, dll_seen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  mode_bl;
    logic [4:0]  debt;
    logic        self_ref, refreshing, dll_on, dll_reset, wr_seen, wr_bl8, banks_idle, dll_en;
    logic [13:0] row_ctr;
    int          mismatches, checked, i;
    dramrf_link_if dramrf_link_if_i ();
    dramrf_ctrl dramrf_ctrl_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .mode_bl_i(mode_bl), .link(dramrf_link_if_i.ctrl));
    dramrf_dram dramrf_dram_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(dramrf_link_if_i.dram),
        .mode_bl_i(mode_bl), .dll_en_i(dll_en), .self_ref_o(self_ref), .refreshing_o(refreshing),
        .banks_idle_o(banks_idle), .row_ctr_o(row_ctr), .dll_on_o(dll_on), .dll_reset_o(dll_reset),
        .wr_seen_o(wr_seen), .wr_bl8_o(wr_bl8));
    dramrf_link_checker dramrf_link_checker_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .ck(dramrf_link_if_i.ck), .cke(dramrf_link_if_i.cke), .cs_n(dramrf_link_if_i.cs_n),
        .ras_n(dramrf_link_if_i.ras_n), .cas_n(dramrf_link_if_i.cas_n), .we_n(dramrf_link_if_i.we_n),
        .odt(dramrf_link_if_i.odt));
    // System clock
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Catch the one-cycle DLL reset pulse
    always @(posedge clk_sys_i) if (dll_reset === 1'b1) dll_seen <= 1'b1;
    // Verdict and end of run
    task complete_run;
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // One APB transfer, waiting for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        @(posedge clk_sys_i);
        while (pready !== 1'b1) @(posedge clk_sys_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        complete_run;
    end
    // Test sequence
    initial begin
        {resetn_i, psel, penable, pwrite, paddr, pwdata, mode_bl, dll_seen, dll_en, mismatches, checked} = '0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("state", 8'h01, rd[7:0])
        `CHK("dll_dis", 1'b0, dll_on)
        dll_en <= 1'b1;
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("slverr", 1'b1, err)
        `CHK("unmapped", 32'h0, rd)
        // Debt rises and stops at eight with no refreshes
        repeat (12 * TREFI_NCK * 2 * CK_HALF) @(posedge clk_sys_i);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("debt_max", 5'h08, rd[12:8])
        // Pulled-in refreshes stop counting at minus eight
        for (i = 0; i < 24; i++) begin
            apb(1'b1, REG_CTRL, 32'h0000_0008);
            repeat (40) @(posedge clk_sys_i);
        end
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("debt_min", 5'h18, rd[12:8])
        // One more pull-in: banks busy during refresh, idle after, row counter advanced
        apb(1'b1, REG_CTRL, 32'h0000_0008);
        while (refreshing !== 1'b1) @(posedge clk_sys_i);
        `CHK("banks_busy", 1'b0, banks_idle)
        while (refreshing !== 1'b0) @(posedge clk_sys_i);
        `CHK("banks_idle", 1'b1, banks_idle)
        `CHK("rows", 14'h0019, row_ctr)
        // Self-refresh entry, internal refresh, frozen debt
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl", 32'h0000_0002, rd)
        while (self_ref !== 1'b1) @(posedge clk_sys_i);
        for (i = 0; i < 40 && refreshing !== 1'b1; i++) @(posedge clk_sys_i);
        `CHK("sr_refresh", 1'b1, refreshing)
        `CHK("dll_off", 1'b0, dll_on)
        apb(1'b0, REG_STATUS, 32'h0);
        debt = rd[12:8];
        `CHK("in_sr", 1'b1, rd[ST_SR])
        repeat (700) @(posedge clk_sys_i);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("debt_frozen", debt, rd[12:8])
        // Exit with DLL reset
        apb(1'b1, REG_CTRL, 32'h0);
        while (self_ref !== 1'b0) @(posedge clk_sys_i);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("dll_reset", 1'b1, dll_seen)
        `CHK("dll_on", 1'b1, dll_on)
        `CHK("extra_ref", 1'b1, rd[ST_NEEDREF])
        // Burst length for each field value and a12
        for (i = 0; i < 4; i++) begin
            mode_bl <= (i == 0) ? BURST_FIXED8 : (i == 3) ? BURST_CHOP4 : BURST_OTF;
            apb(1'b1, REG_WRCMD, {31'h0, i[0]});
            while (wr_seen !== 1'b1) @(posedge clk_sys_i);
            @(posedge clk_sys_i);
            `CHK("bl8", (i < 2), wr_bl8)
        end
        complete_run;
    end
endmodule : testbench
